/* File: timer_watchdog_unit.sv */
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module timer_watchdog_unit
  import twm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Slow clock from pin
  input  wire logic        slow_clock_in,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // Outputs
  output logic             timer_irq_line,
  output logic             timer_zero_pulse,
  output logic             wd_reset_out
);

  // Overview of the block as a whole:
  // The slow clock pin is sampled by the system clock.
  // Every counter steps on slow clock rises only.
  // No counter runs on its own free clock domain.
  // This keeps the unit a single clock design.
  // The prescaler counts slow clock rises.
  // A masked view of it yields the prescaled tick.
  // The periodic timer steps once per tick.
  // Its zero event feeds the flag and pulse.
  // The watchdog steps on tick or zero pulse.
  // Servicing reloads the watchdog counter.
  // Errors raise a one cycle reset request.
  // Locks in the config byte gate all writes except to the match register.
  // Locked reads return a fixed junk word.
  // Locks only clear on the block reset.
  // Software sees six word spaced offsets.
  // Unmapped offsets read back as zero.
  // The match register reads back as zero.
  // Read data stand for one cycle only.
  // Outside that cycle the read bus is zero.

  // Slow clock synchroniser
  // First stage may go metastable
  // Second stage is the first one read
  // Third stage only delays for edge detect
  logic sync_a;
  logic sync_b;
  logic sync_c;
  wire  slow_rise = sync_b & ~sync_c;

  // Registers
  logic [7:0]  twm_config;
  logic [2:0]  prescale_select;
  logic [15:0] timer_reload_value;
  logic        timer_irq_enable;
  logic        restart;
  logic        terminal_count_flag;
  logic [7:0]  wd_count_value;
  // Counters
  logic [4:0]  prescale_cnt;
  logic [15:0] timer_cnt;
  logic [7:0]  wd_cnt;
  wd_state_e   wd_state;
  logic        served;           // Service seen this watchdog period
  timer_event_s ev;
  logic        zero_pulse_hold;  // Pulse held for one tick period

  // Divisor decode
  // Select code N divides by two to the N
  // Mask picks the low prescaler bits
  // Tick fires when masked bits are all zero
  // Code zero gives a tick on every rise
  // Codes above five are refused at write
  // So the default branch is reached by code five only
  // It still gives the slowest divisor
  function automatic logic [4:0] div_mask(input logic [2:0] sel);
    case (sel)
      3'd0:    div_mask = 5'h00;
      3'd1:    div_mask = 5'h01;
      3'd2:    div_mask = 5'h03;
      3'd3:    div_mask = 5'h07;
      3'd4:    div_mask = 5'h0F;
      default: div_mask = 5'h1F;
    endcase
  endfunction

  // Lock views
  // Each lock bit is one config bit
  // Timer lock guards reload and control
  // The match register has no lock
  // Servicing by key works when all locked
  wire lk_cfg = twm_config[bit_lock_config];
  wire lk_pre = twm_config[bit_lock_prescale];
  wire lk_tmr = twm_config[bit_lock_timer];
  wire lk_wdc = twm_config[bit_lock_wd_count];
  wire match_en = twm_config[bit_match_enable];

  // Write decode, locks gate writes
  wire wr_cfg   = wr & (addr == off_config)   & ~lk_cfg;
  wire wr_pre   = wr & (addr == off_prescale) & ~lk_pre;
  wire wr_rel   = wr & (addr == off_reload)   & ~lk_tmr;
  wire wr_ctl   = wr & (addr == off_ctrl)     & ~lk_tmr;
  wire wr_wdc   = wr & (addr == off_wd_count) & ~lk_wdc;
  wire wr_match = wr & (addr == off_wd_match);

  // Tick and zero events
  // Tick is one system clock wide
  // Zero is a tick seen with count at zero
  // A pending restart hides the zero event
  // Restart reloads instead of reporting zero
  // Both events travel as one packed struct
  assign ev.tick = slow_rise & ((prescale_cnt & div_mask(prescale_select)) == 5'h00);
  assign ev.zero = ev.tick & (timer_cnt == 16'h0000) & ~restart;

  // Watchdog clock select
  wire wd_clk_ev = twm_config[bit_wd_clock_sel] ? ev.tick : ev.zero;

  // Service events
  // Count write services only when match is off
  // Key write services only when match is on
  // Wrong key with match on is an error
  // Key writes with match off only start an idle watchdog
  // Either register write starts the watchdog
  // Writes to a locked count do not start it
  wire svc_count = wr_wdc & ~match_en;
  wire svc_match = wr_match & match_en & (wdata[7:0] == wd_match_key);
  wire bad_match = wr_match & match_en & (wdata[7:0] != wd_match_key);
  wire service   = svc_count | svc_match;
  wire start_wd  = wr_wdc | wr_match;

  // Error sources
  // Late: watchdog event while count is zero
  // A service in the same cycle rescues it
  // Often: second service in one period
  // Period ends at the next watchdog event
  // Bad key counts only once running
  // Idle watchdog never raises an error
  wire err_late  = (wd_state == wd_running) & wd_clk_ev & (wd_cnt == 8'h00) & ~service;
  wire err_often = (wd_state == wd_running) & service & served;
  wire wd_error  = err_late | err_often | ((wd_state == wd_running) & bad_match);

  // Output pins
  assign timer_zero_pulse = zero_pulse_hold;
  assign timer_irq_line   = zero_pulse_hold & timer_irq_enable;

  // Synchroniser
  // Reset level matches the idle low pin
  // So no false rise follows reset
  // Rise seen about two clocks after pin
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= slow_clock_in;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  // Prescaler
  // Free running count of slow clock rises
  // Wraps after thirty two rises
  // Changing the select shifts tick phase once
  // Software should restart the timer after it
  always_ff @(posedge clk) begin
    if (srst) prescale_cnt <= 5'h00;
    else if (slow_rise) prescale_cnt <= prescale_cnt + 5'h01;
  end

  // Configuration, locks sticky
  always_ff @(posedge clk) begin
    if (srst) twm_config <= config_reset;
    else if (wr_cfg) twm_config <= {2'b00, wdata[5:4], twm_config[3:0] | wdata[3:0]};
  end

  // Prescale select
  always_ff @(posedge clk) begin
    if (srst) prescale_select <= prescale_reset;
    else if (wr_pre && wdata[2:0] <= 3'(max_select)) prescale_select <= wdata[2:0];
  end

  // Reload value; takes effect at next reload
  always_ff @(posedge clk) begin
    if (srst) timer_reload_value <= reload_reset;
    else if (wr_rel) timer_reload_value <= wdata;
  end

  // Control and status
  always_ff @(posedge clk) begin
    if (srst) begin
      timer_irq_enable    <= 1'b0;
      restart             <= 1'b0;
      terminal_count_flag <= 1'b0;
    end else begin
      if (wr_ctl) timer_irq_enable <= wdata[bit_irq_enable];
      if (ev.tick && restart) restart <= 1'b0;
      else if (wr_ctl && wdata[bit_restart]) restart <= 1'b1;
      // Set wins over write-one-to-clear
      if (ev.zero) terminal_count_flag <= 1'b1;
      else if (wr_ctl && wdata[bit_term_flag]) terminal_count_flag <= 1'b0;
    end
  end

  // Timer counter
  // Period is reload plus one ticks
  // Reload value is only read at reload
  // So a new value waits for the next zero or restart
  // Zero reload is refused by software rule
  // With zero reload the timer would stick
  always_ff @(posedge clk) begin
    if (srst) timer_cnt <= reload_reset;
    else if (ev.tick) begin
      if (restart || timer_cnt == 16'h0000) timer_cnt <= timer_reload_value;
      else timer_cnt <= timer_cnt - 16'h0001;
    end
  end

  // Zero pulse lasts one tick period
  always_ff @(posedge clk) begin
    if (srst) zero_pulse_hold <= 1'b0;
    else if (ev.tick) zero_pulse_hold <= ev.zero;
  end

  // Watchdog count register
  always_ff @(posedge clk) begin
    if (srst) wd_count_value <= wd_count_reset;
    else if (wr_wdc) wd_count_value <= wdata[7:0];
  end

  // Watchdog state and counter
  // Idle until first count or key write
  // Running has no path back to idle
  // Only the block reset leaves running
  // Counter holds at zero after expiry
  // Late errors then repeat every event
  // Served flag marks a service this period
  // Flag set wins over the period end
  always_ff @(posedge clk) begin
    if (srst) begin
      wd_state <= wd_idle;
      wd_cnt   <= wd_count_reset;
      served   <= 1'b0;
    end else begin
      case (wd_state)
        wd_idle: begin
          if (start_wd) begin
            wd_state <= wd_running;
            wd_cnt   <= wr_wdc ? wdata[7:0] : wd_count_value;
          end
        end
        wd_running: begin
          if (svc_count) wd_cnt <= wdata[7:0];
          else if (svc_match) wd_cnt <= wd_count_value;
          else if (wd_clk_ev && wd_cnt != 8'h00) wd_cnt <= wd_cnt - 8'h01;
          if (service) served <= 1'b1;
          else if (wd_clk_ev) served <= 1'b0;
        end
        default: wd_state <= wd_idle;
      endcase
    end
  end

  // Device reset request
  always_ff @(posedge clk) begin
    if (srst) wd_reset_out <= 1'b0;
    else wd_reset_out <= wd_error;
  end

  // Read mux; locked registers return junk
  // Junk is a fixed word, not live state
  // Hides the register from runaway code
  // Reserved bits read back as zero
  // Flag, restart and enable share one word
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    case (addr)
      off_config:   next_rdata = lk_cfg ? junk_read : {8'h00, twm_config};
      off_prescale: next_rdata = lk_pre ? junk_read : {13'h0000, prescale_select};
      off_reload:   next_rdata = lk_tmr ? junk_read : timer_reload_value;
      off_ctrl:     next_rdata = lk_tmr ? junk_read :
                      {13'h0000, terminal_count_flag, restart, timer_irq_enable};
      off_wd_count: next_rdata = lk_wdc ? junk_read : {8'h00, wd_count_value};
      default:      next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) rdata <= 16'h0000;
    else if (rd) rdata <= next_rdata;
    else rdata <= 16'h0000;
  end

endmodule // timer_watchdog_unit
`default_nettype wire

/* File: twm_pkg.sv */
// What this block does
// - Prescaler divides by 1,2,4,8,16,32
// - All counting driven from slow clock
// - Timer is 16-bit down-counter on tick
// - Timer auto-reloads at zero
// - Zero pulse one tick; sets flag
// - Interrupt line gated by enable bit
// - Zero pulse exported to wake-up unit
// - New reload used at next reload
// - Restart reloads next tick, self-clears
// - Watchdog is 8-bit down-counter
// - Watchdog idle until count/match write
// - Started watchdog stops only on reset
// - Clock select: zero pulse or tick
// - Count write services when match off
// - Match 5Ch reloads stored count
// - Error on late or frequent service
// - Wrong match value raises error
// - Watchdog error resets the device
// - Locked register ignores writes, reads junk
// - Locks persist until device reset
// - Config holds selects and lock bits
// - Config clears at reset
// - Timer lock covers reload and control
`default_nettype none
package twm_pkg;
  // Register offsets
  localparam logic [3:0] off_config   = 4'h0;
  localparam logic [3:0] off_prescale = 4'h2;
  localparam logic [3:0] off_reload   = 4'h4;
  localparam logic [3:0] off_ctrl     = 4'h6;
  localparam logic [3:0] off_wd_count = 4'h8;
  localparam logic [3:0] off_wd_match = 4'hA;
  // Config field positions
  localparam int bit_lock_config   = 0;
  localparam int bit_lock_prescale = 1;
  localparam int bit_lock_timer    = 2;
  localparam int bit_lock_wd_count = 3;
  localparam int bit_wd_clock_sel  = 4;
  localparam int bit_match_enable  = 5;
  // Control/status field positions
  localparam int bit_irq_enable    = 0;
  localparam int bit_restart       = 1;
  localparam int bit_term_flag     = 2;
  // Values
  localparam logic [7:0]  wd_match_key   = 8'h5C;
  localparam logic [7:0]  config_reset   = 8'h00;
  localparam logic [2:0]  prescale_reset = 3'h0;
  localparam logic [15:0] reload_reset   = 16'hFFFF;
  localparam logic [7:0]  wd_count_reset = 8'hFF;
  localparam logic [15:0] junk_read      = 16'hDEAD;
  localparam int          max_select     = 5;
  // Watchdog state
  typedef enum logic {wd_idle, wd_running} wd_state_e;
  // Timer events grouped together
  typedef struct packed {
    logic tick;
    logic zero;
  } timer_event_s;
endpackage
`default_nettype wire

/* File: twm_props.sv */
`timescale 1ns/100ps
`default_nettype none
module twm_props
  import twm_pkg::*;
(
  // Watched ports
  input wire logic        clk, srst, slow_clock_in, wr, rd,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata, rdata,
  input wire logic        timer_irq_line, timer_zero_pulse, wd_reset_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Mirrors of config, irq enable and watchdog start
  logic [5:0] cfg;
  logic       ien, run;
  wire wc = wr && addr == off_config && !cfg[0];
  wire lk = (addr == off_config && cfg[0]) || (addr == off_prescale && cfg[1]) ||
            (addr == off_wd_count && cfg[3]);
  // Locks only ever gain bits
  always_ff @(posedge clk)
    cfg <= srst ? 6'h00 : wc ? {wdata[5:4], cfg[3:0] | wdata[3:0]} : cfg;
  always_ff @(posedge clk)
    ien <= srst ? 1'b0 : (wr && addr == off_ctrl && !cfg[2]) ? wdata[0] : ien;
  always_ff @(posedge clk)
    run <= !srst && (run || (wr && (addr == off_wd_count || addr == off_wd_match)));
  chk_irq_gated: assert property (timer_irq_line |-> timer_zero_pulse && ien)
    else $error("irq without pulse and enable");
  chk_irq_raised: assert property (timer_zero_pulse && ien |-> timer_irq_line)
    else $error("irq missing");
  chk_pulse_width: assert property ($rose(timer_zero_pulse) |=> timer_zero_pulse [*3])
    else $error("zero pulse too short");
  chk_wd_idle: assert property (!run |-> !wd_reset_out)
    else $error("watchdog error before start");
  chk_bad_match: assert property (wr && addr == off_wd_match && run && cfg[5] &&
    wdata[7:0] != wd_match_key |=> wd_reset_out) else $error("bad key not caught");
  chk_cfg_read: assert property (rd && addr == off_config && !cfg[0] |=>
    rdata[5:0] == $past(cfg)) else $error("config read mismatch");
  chk_locked_read: assert property (rd && lk |=> rdata == junk_read)
    else $error("locked read not junk");
  chk_timer_lock: assert property (rd && cfg[2] && addr == off_ctrl |=>
    rdata == junk_read) else $error("timer lock ignored");
  cov_pulse: cover property ($rose(timer_zero_pulse) && ien);
  cov_wd_err: cover property (wd_reset_out);
  cov_locked: cover property (rd && lk);
endmodule // twm_props
bind timer_watchdog_unit twm_props i_props (.clk, .srst, .slow_clock_in, .wr, .rd, .addr,
  .wdata, .rdata, .timer_irq_line, .timer_zero_pulse, .wd_reset_out);
`default_nettype wire

/* File: timer_watchdog_unit_test.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module timer_watchdog_unit_test
  import twm_pkg::*;
;
  logic        clk = 0, srst = 1, slow = 0, wr = 0, rd = 0, seen = 0;
  logic [3:0]  addr = 0;
  logic [15:0] wdata = 0, rdata, v;
  logic        irq, zp, wdr;
  logic [31:0] seed = 73;
  int          errors = 0, checks = 0, cyc = 0, t0, t1, t2, n, m, d;
  // Slow clock is exactly 8 system clocks
  always #50 clk = ~clk;
  always #400 slow = ~slow;
  // Cycle count and sticky watchdog error
  always @(posedge clk) begin
    cyc <= cyc + 1;
    seen <= !srst && (seen || wdr);
  end
  timer_watchdog_unit i_timer_watchdog_unit (.clk, .srst, .slow_clock_in(slow), .addr,
    .wdata, .wr, .rd, .rdata, .timer_irq_line(irq), .timer_zero_pulse(zp), .wd_reset_out(wdr));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wreg(input logic [3:0] a, input logic [15:0] dv);
    @(posedge clk);
    addr <= a;
    wdata <= dv;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 v = rdata;
  endtask
  task automatic rst();
    @(posedge clk);
    srst <= 1;
    repeat (3) @(posedge clk);
    srst <= 0;
  endtask
  // Time of the next rise of the zero pulse
  task automatic tz(output int t);
    d = 0;
    while (zp !== 1'b0 && d < 9000) begin @(posedge clk); #1 d++; end
    while (zp !== 1'b1 && d < 9000) begin @(posedge clk); #1 d++; end
    t = cyc;
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #2_000_000;
    errors++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clk);
    srst <= 0;
    rreg(off_config);
    `CHK("config", 16'h0000, v)
    // Every divisor, reload swapped mid-count
    for (int s = 0; s <= max_select; s++) begin
      n = 1 + rnd() % 4;
      m = 1 + rnd() % 4;
      wreg(off_prescale, 16'(s));
      wreg(off_reload, 16'(n));
      wreg(off_ctrl, 16'h0003);
      tz(t0);
      wreg(off_reload, 16'(m));
      tz(t1);
      tz(t2);
      `CHK("irq", 1'b1, irq)
      `CHK("period old", (n + 1) * 8 << s, t1 - t0)
      `CHK("period new", (m + 1) * 8 << s, t2 - t1)
      rreg(off_ctrl);
      `CHK("ctrl", 3'b101, v[2:0])
    end
    $display("timer test done");
    rst();
    n = 4 + rnd() % 8;
    wreg(off_config, 16'h0010);
    repeat (4) begin
      wreg(off_wd_count, 16'(n));
      repeat (20) @(posedge clk);
    end
    `CHK("serviced", 1'b0, seen)
    t0 = cyc;
    wreg(off_wd_count, 16'(n));
    while (seen !== 1'b1 && cyc < t0 + 500) @(posedge clk);
    `CHK("late", 1'b1, seen && cyc - t0 >= n * 8 && cyc - t0 <= n * 8 + 24)
    $display("late test done");
    rst();
    wreg(off_reload, 16'h0001);
    wreg(off_ctrl, 16'h0002);
    wreg(off_config, 16'h0030);
    wreg(off_wd_count, 16'h0010);
    repeat (2) begin
      repeat (20) @(posedge clk);
      wreg(off_wd_match, 16'(wd_match_key));
    end
    `CHK("matched", 1'b0, seen)
    tz(t0);
    wreg(off_wd_match, 16'(wd_match_key));
    wreg(off_wd_match, 16'(wd_match_key));
    repeat (3) @(posedge clk);
    `CHK("often", 1'b1, seen)
    $display("match test done");
    rst();
    wreg(off_config, 16'h0020);
    wreg(off_wd_count, 16'h0040);
    repeat (20) @(posedge clk);
    v = 16'(rnd());
    if (v[7:0] == wd_match_key) v = 16'h005D;
    wreg(off_wd_match, v);
    repeat (3) @(posedge clk);
    `CHK("bad key", 1'b1, seen)
    $display("key test done");
    rst();
    wreg(off_config, 16'h0008);
    wreg(off_config, 16'h0000);
    rreg(off_config);
    `CHK("sticky", 16'h0008, v)
    rreg(off_wd_count);
    `CHK("locked count", junk_read, v)
    rreg(4'hE);
    `CHK("unmapped", 16'h0000, v)
    wreg(off_config, 16'h0005);
    rreg(off_config);
    `CHK("locked config", junk_read, v)
    rreg(off_ctrl);
    `CHK("locked ctrl", junk_read, v)
    rreg(off_prescale);
    `CHK("prescale", 16'(prescale_reset), v)
    $display("lock test done");
    test_done();
  end
endmodule // timer_watchdog_unit_test
`default_nettype wire
